// ### cwt_cfg.svh
`ifndef CWT_CFG_SVH
`define CWT_CFG_SVH

// ****************************************************************
// Register map (byte addresses, one 32-bit word each)
// ****************************************************************
`define CWT_ADDR_W        8             // Register address width
`define CWT_DATA_W        32            // Register data width
`define CWT_TIMER_STRIDE  8'h10         // Address step between timers
`define CWT_OFS_ON        2'h0          // Word index: on-time
`define CWT_OFS_OFF       2'h1          // Word index: off-time
`define CWT_OFS_MODE      2'h2          // Word index: repetition mode
`define CWT_OFS_STATUS    2'h3          // Word index: timer status

// ****************************************************************
// Field layout
// ****************************************************************
`define CWT_TOD_W         17            // Packed hh:mm:ss width
`define CWT_HH_MSB        16            // Hours field [16:12]
`define CWT_HH_LSB        12
`define CWT_MM_MSB        11            // Minutes field [11:6]
`define CWT_MM_LSB        6
`define CWT_SS_MSB        5             // Seconds field [5:0]
`define CWT_SS_LSB        0
`define CWT_MODE_W        4             // Mode field [3:0]
`define CWT_STAT_OUT_BIT  0             // Status: output active
`define CWT_STAT_USE_BIT  1             // Status: timer in use

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define CWT_NUM_TIMERS    4             // Independent calendar timers
`define CWT_TOD_RST       17'h00000     // Times reset to 00:00:00
`define CWT_MODE_RST      4'h0          // Mode resets to disabled
`define CWT_DAY_W         3             // Weekday code width, 0 = Monday

`endif

// ### cwt_pkg.sv
package cwt_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Repetition modes; the order gives the stored code
  typedef enum logic [3:0] {
    cwt_disabled,
    cwt_daily,
    cwt_monday,
    cwt_tuesday,
    cwt_wednesday,
    cwt_thursday,
    cwt_friday,
    cwt_saturday,
    cwt_sunday,
    weekdays_only_mode,
    mon_to_sat_mode,
    weekend_only_mode
  } cwt_mode_e;

  typedef logic [16:0] cwt_tod_t;       // Packed hh:mm:ss
  typedef logic [2:0]  cwt_day_t;       // Weekday, 0 = Monday .. 6 = Sunday

endpackage : cwt_pkg

// ### cwt_cfg_mem.sv
`include "cwt_cfg.svh"

// ****************************************************************
// Per-timer settings store: one write port, two registered reads
// ****************************************************************
module cwt_cfg_mem
  import cwt_pkg::*;
#(
  parameter int N = 4                   // Number of timer entries
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   arst_n_in,
  input  wire logic                   we_in,        // Write one field
  input  wire logic [1:0]             wsel_in,      // Field select
  input  wire logic [$clog2(N)-1:0]   waddr_in,     // Entry to write
  input  wire logic [16:0]            wdata_in,     // Field value
  input  wire logic [$clog2(N)-1:0]   ra_bus_in,    // Bus read entry
  input  wire logic [1:0]             rsel_bus_in,  // Bus read field
  output logic      [16:0]            rq_bus_out,   // Bus read data
  input  wire logic [$clog2(N)-1:0]   ra_scan_in,   // Scan read entry
  output logic      [16:0]            on_q_out,     // Scan: on-time
  output logic      [16:0]            off_q_out,    // Scan: off-time
  output logic      [3:0]             mode_q_out    // Scan: mode code
);

  logic [16:0] on_mem  [N];             // On-times
  logic [16:0] off_mem [N];             // Off-times
  logic [3:0]  mode_mem[N];             // Mode codes

  // ****************************************************************
  // Storage, one generate entry per timer
  // ****************************************************************
  for (genvar g = 0; g < N; g++) begin : g_entry
    // Each entry only sees its own write, so timers stay independent
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        on_mem[g]   <= `CWT_TOD_RST;
        off_mem[g]  <= `CWT_TOD_RST;
        mode_mem[g] <= `CWT_MODE_RST;
      end else if (we_in && (waddr_in == g)) begin
        if (wsel_in == `CWT_OFS_ON)   on_mem[g]   <= wdata_in;
        if (wsel_in == `CWT_OFS_OFF)  off_mem[g]  <= wdata_in;
        if (wsel_in == `CWT_OFS_MODE) mode_mem[g] <= wdata_in[3:0];
      end
    end
  end

  // Bus-side field selection
  wire logic [16:0] bus_sel_w = (rsel_bus_in == `CWT_OFS_ON)   ? on_mem[ra_bus_in]  :
                                (rsel_bus_in == `CWT_OFS_OFF)  ? off_mem[ra_bus_in] :
                                (rsel_bus_in == `CWT_OFS_MODE) ? {13'h0000, mode_mem[ra_bus_in]} :
                                17'h00000;

  // ****************************************************************
  // Registered read ports
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rq_bus_out <= 17'h00000;
      on_q_out   <= 17'h00000;
      off_q_out  <= 17'h00000;
      mode_q_out <= 4'h0;
    end else begin
      rq_bus_out <= bus_sel_w;
      on_q_out   <= on_mem[ra_scan_in];
      off_q_out  <= off_mem[ra_scan_in];
      mode_q_out <= mode_mem[ra_scan_in];
    end
  end

endmodule : cwt_cfg_mem

// ### cwt_timers.sv
`include "cwt_cfg.svh"

module cwt_timers
  import cwt_pkg::*;
#(
  parameter int N = `CWT_NUM_TIMERS     // Timer count
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    arst_n_in,
  // Register port
  input  wire logic [`CWT_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [`CWT_DATA_W-1:0]  reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [`CWT_DATA_W-1:0]  reg_rdata_out,
  // Real-time clock
  input  wire logic                    rtc_sec_tick_in,
  input  wire logic [4:0]              rtc_hour_in,
  input  wire logic [5:0]              rtc_min_in,
  input  wire logic [5:0]              rtc_sec_in,
  input  wire logic [`CWT_DAY_W-1:0]   rtc_weekday_in,
  // Non-volatile status keeping
  input  wire logic                    power_fail_in,
  output logic                         nv_save_out,
  output logic      [N-1:0]            nv_state_out,
  input  wire logic                    nv_restore_in,
  input  wire logic [N-1:0]            nv_state_in,
  // Timer outputs to user logic and routing matrix
  output logic      [N-1:0]            calendar_timer_state_out
);

  localparam int IW = $clog2(N);        // Timer index width

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire logic          addr_ok_w  = (reg_addr_in[7:6] == 2'h0) &&
                                   (reg_addr_in[1:0] == 2'h0);   // Mapped word
  wire logic [IW-1:0] tsel_w     = reg_addr_in[4 +: IW];         // Timer select
  wire logic [1:0]    fsel_w     = reg_addr_in[3:2];             // Field select
  wire logic          wr_ok_w    = reg_wr_in && addr_ok_w;       // Mapped write
  wire logic          wr_cfg_w   = wr_ok_w && (fsel_w != `CWT_OFS_STATUS);
  wire logic          wr_mode_w  = wr_ok_w && (fsel_w == `CWT_OFS_MODE);
  wire logic          wr_stat_w  = wr_ok_w && (fsel_w == `CWT_OFS_STATUS);
  wire logic          rd_mem_w   = reg_rd_in && addr_ok_w && (fsel_w != `CWT_OFS_STATUS);
  wire logic          rd_stat_w  = reg_rd_in && addr_ok_w && (fsel_w == `CWT_OFS_STATUS);

  // Mode codes above the last mode are not legal; they count as disabled
  wire logic          mode_use_w = (reg_wdata_in[3:0] != `CWT_MODE_RST) &&
                                   (reg_wdata_in[3:0] <= 4'(weekend_only_mode));

  // ****************************************************************
  // State
  // ****************************************************************
  logic [N-1:0]   inuse_r;              // Mode not disabled, per timer
  logic [N-1:0]   state_r;              // Timer output state
  logic [N-1:0]   state_nxt;
  logic           scan_busy_r;          // Scan of all timers running
  logic [IW-1:0]  scan_idx_r;           // Entry being read
  logic           scan_val_r;           // Memory data valid this cycle
  logic [IW-1:0]  scan_vidx_r;          // Entry that the data belong to
  cwt_tod_t       tod_r;                // Time of day latched at the tick
  cwt_day_t       day_r;                // Weekday latched at the tick
  logic           rd_mem_r;             // Last read went to the store
  logic [1:0]     rd_stat_r;            // Status read data, else zero
  logic [16:0]    mem_rq_w;             // Store bus read data
  logic [16:0]    on_q_w;               // Scanned on-time
  logic [16:0]    off_q_w;              // Scanned off-time
  logic [3:0]     mode_q_w;             // Scanned mode code

  // Settings live in their own store, one entry per timer
  cwt_cfg_mem #(.N(N)) u_mem (
    .clk_sys_in  (clk_sys_in),
    .arst_n_in   (arst_n_in),
    .we_in       (wr_cfg_w),
    .wsel_in     (fsel_w),
    .waddr_in    (tsel_w),
    .wdata_in    (reg_wdata_in[16:0]),
    .ra_bus_in   (tsel_w),
    .rsel_bus_in (fsel_w),
    .rq_bus_out  (mem_rq_w),
    .ra_scan_in  (scan_idx_r),
    .on_q_out    (on_q_w),
    .off_q_out   (off_q_w),
    .mode_q_out  (mode_q_w)
  );

  // ****************************************************************
  // Day qualification
  // ****************************************************************
  // One table for every mode; Monday is day 0, Sunday day 6
  function automatic logic day_qual(input logic [3:0] mode, input cwt_day_t day);
    logic q;
    q = 1'b0;
    unique case (mode)
      cwt_daily:          q = 1'b1;
      cwt_monday:         q = (day == 3'h0);
      cwt_tuesday:        q = (day == 3'h1);
      cwt_wednesday:      q = (day == 3'h2);
      cwt_thursday:       q = (day == 3'h3);
      cwt_friday:         q = (day == 3'h4);
      cwt_saturday:       q = (day == 3'h5);
      cwt_sunday:         q = (day == 3'h6);
      weekdays_only_mode: q = (day <= 3'h4);
      mon_to_sat_mode:    q = (day <= 3'h5);
      weekend_only_mode:  q = (day == 3'h5) || (day == 3'h6);
      default:            q = 1'b0;
    endcase
    return q;
  endfunction : day_qual

  // Scheduled events for the entry whose settings just came out
  wire logic qual_w   = scan_val_r && day_qual(mode_q_w, day_r);
  wire logic ev_on_w  = qual_w && (tod_r == on_q_w);
  wire logic ev_off_w = qual_w && (tod_r == off_q_w) && !ev_on_w;

  // ****************************************************************
  // Once-per-second scan of all timers
  // ****************************************************************
  // A tick during a running scan is dropped; the scan takes N cycles,
  // far shorter than a second, so this never happens in practice
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_busy_r <= 1'b0;
      scan_idx_r  <= '0;
      tod_r       <= `CWT_TOD_RST;
      day_r       <= '0;
    end else if (!scan_busy_r) begin
      if (rtc_sec_tick_in) begin
        scan_busy_r <= 1'b1;
        scan_idx_r  <= '0;
        tod_r       <= {rtc_hour_in, rtc_min_in, rtc_sec_in};
        day_r       <= rtc_weekday_in;
      end
    end else begin
      scan_idx_r  <= IW'(scan_idx_r + 1'b1);
      scan_busy_r <= (scan_idx_r != IW'(N - 1));
    end
  end

  // Store data lag the address by one cycle
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_val_r  <= 1'b0;
      scan_vidx_r <= '0;
    end else begin
      scan_val_r  <= scan_busy_r;
      scan_vidx_r <= scan_idx_r;
    end
  end

  // ****************************************************************
  // Timer state, one generate slice per timer
  // ****************************************************************
  for (genvar g = 0; g < N; g++) begin : g_timer
    wire logic hit_w   = (scan_vidx_r == g);                 // Scan on this timer
    wire logic wsel_w  = (tsel_w == g);                      // Bus on this timer
    wire logic force_w = wr_stat_w && wsel_w && inuse_r[g];

    // A scheduled switch wins over a force in the same cycle;
    // a force otherwise stands until the next opposite switch
    always_comb begin
      state_nxt[g] = state_r[g];
      if (!inuse_r[g]) begin
        state_nxt[g] = 1'b0;
      end else if (hit_w && ev_on_w) begin
        state_nxt[g] = 1'b1;
      end else if (hit_w && ev_off_w) begin
        state_nxt[g] = 1'b0;
      end else if (force_w) begin
        state_nxt[g] = reg_wdata_in[`CWT_STAT_OUT_BIT];
      end else if (nv_restore_in) begin
        state_nxt[g] = nv_state_in[g];
      end
    end

    // In-use flag follows the mode written to this timer alone
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        inuse_r[g] <= 1'b0;
      end else if (wr_mode_w && wsel_w) begin
        inuse_r[g] <= mode_use_w;
      end
    end
  end

  // Disabling a timer clears its output in the same edge
  wire logic [N-1:0] inuse_nxt_w;
  for (genvar g = 0; g < N; g++) begin : g_use
    assign inuse_nxt_w[g] = (wr_mode_w && (tsel_w == g)) ? mode_use_w : inuse_r[g];
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt & inuse_nxt_w;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Outputs mirror the state register straight to the consumers
  assign calendar_timer_state_out = state_r;

  // Snapshot of all states for the non-volatile store
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nv_save_out  <= 1'b0;
      nv_state_out <= '0;
    end else begin
      nv_save_out <= power_fail_in;
      if (power_fail_in) begin
        nv_state_out <= state_r;
      end
    end
  end

  // ****************************************************************
  // Register read path
  // ****************************************************************
  wire logic [1:0] stat_sel_w = {inuse_r[tsel_w], state_r[tsel_w]};

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_mem_r  <= 1'b0;
      rd_stat_r <= 2'h0;
    end else begin
      rd_mem_r  <= rd_mem_w;
      rd_stat_r <= rd_stat_w ? stat_sel_w : 2'h0;
    end
  end

  // Both sources are registers; the select only steers between them
  assign reg_rdata_out = rd_mem_r ? {15'h0000, mem_rq_w} : {30'h00000000, rd_stat_r};

  // ****************************************************************
  // Checks
  // ****************************************************************
  // A whole scan: tick then four busy cycles then idle
  sequence s_scan_run;
    scan_busy_r [*4] ##1 !scan_busy_r;
  endsequence

  a_scan_length: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (rtc_sec_tick_in && !scan_busy_r) |=> s_scan_run)
    else $error("Scan did not run four cycles");

  a_disabled_zero: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (calendar_timer_state_out & ~inuse_r) == '0)
    else $error("Disabled timer output is high");

  a_sched_on: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (ev_on_w && inuse_r[scan_vidx_r]) |=> calendar_timer_state_out[$past(scan_vidx_r)]
      || !inuse_r[$past(scan_vidx_r)])
    else $error("On-time match did not set output");

  a_sched_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ev_off_w |=> !calendar_timer_state_out[$past(scan_vidx_r)])
    else $error("Off-time match did not clear output");

  a_weekend_days: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (scan_val_r && mode_q_w == weekend_only_mode) |-> (qual_w == (day_r >= 3'h5 && day_r <= 3'h6)))
    else $error("Weekend qualification wrong");

  a_workdays_only: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (scan_val_r && mode_q_w == weekdays_only_mode && day_r >= 3'h5) |-> !qual_w)
    else $error("Weekday mode fired on weekend");

  a_force_write: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_stat_w && inuse_r[tsel_w] && !scan_val_r && !wr_mode_w) |=>
      calendar_timer_state_out[$past(tsel_w)] == $past(reg_wdata_in[0]))
    else $error("Status write did not force output");

  a_nv_save: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    power_fail_in |=> nv_save_out && (nv_state_out == $past(state_r)))
    else $error("Power-fail save wrong");

  a_read_once: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (!reg_rd_in) |=> (reg_rdata_out == '0))
    else $error("Read data outside read cycle");

  // Output moves only on a cause
  a_hold_quiet: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (!scan_val_r && !wr_stat_w && !wr_mode_w && !nv_restore_in) |=>
      $stable(calendar_timer_state_out))
    else $error("Output moved with no cause");

  // Disabling mode drops the output
  a_mode_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_mode_w && !mode_use_w) |=> !calendar_timer_state_out[$past(tsel_w)])
    else $error("Disable left output high");

  // Restore loads timers in use
  a_restore_load: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (nv_restore_in && !scan_val_r && !wr_stat_w && !wr_mode_w) |=>
      (calendar_timer_state_out == ($past(nv_state_in) & inuse_r)))
    else $error("Restore load wrong");

  // Status read: in-use and output bits
  a_stat_read: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    rd_stat_w |=> (reg_rdata_out == {30'h00000000, $past(inuse_r[tsel_w]),
                                     $past(calendar_timer_state_out[tsel_w])}))
    else $error("Status read data wrong");

  // Daily mode qualifies every day
  a_daily_all: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (scan_val_r && mode_q_w == cwt_daily) |-> qual_w)
    else $error("Daily mode missed a day");

  // Single-day mode: own weekday only
  a_single_day: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (scan_val_r && mode_q_w >= cwt_monday && mode_q_w <= cwt_sunday) |->
      (qual_w == (day_r == 3'(mode_q_w - cwt_monday))))
    else $error("Single-day qualification wrong");

  // Sunday alone is skipped
  a_sunday_skip: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (scan_val_r && mode_q_w == mon_to_sat_mode && day_r <= 3'h6) |->
      (qual_w == (day_r != 3'h6)))
    else $error("Six-day qualification wrong");

  // Disabled and illegal codes never qualify
  a_idle_mode: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (scan_val_r && (mode_q_w == cwt_disabled || mode_q_w > weekend_only_mode)) |-> !qual_w)
    else $error("Disabled mode qualified");

endmodule : cwt_timers

// ### cwt_rtc_model.sv
// ****************************************************************
// Real-time clock stand-in: one second tick on request
// ****************************************************************
module cwt_rtc_model
  import cwt_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  input  wire logic        req_in,     // Ask for one tick
  input  wire logic [19:0] time_in,    // Hour, minute, second, weekday
  output logic             tick_out,   // One-cycle second pulse
  output logic      [4:0]  hour_out,
  output logic      [5:0]  min_out,
  output logic      [5:0]  sec_out,
  output logic      [2:0]  day_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        tick_r;  // Pulse register
  logic [19:0] time_r;  // Time held for the pulse

  // Latch the requested time, pulse once
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_r <= 1'b0;
      time_r <= 20'h00000;
    end else begin
      tick_r <= req_in;
      if (req_in) begin
        time_r <= time_in;
      end
    end
  end

  // Time only valid beside the tick; inverted otherwise so late sampling shows
  assign tick_out = tick_r;
  assign {hour_out, min_out, sec_out, day_out} = tick_r ? time_r : ~time_r;
endmodule : cwt_rtc_model

// ### calendar_weekday_timers_bench.sv
`include "cwt_cfg.svh"

module calendar_weekday_timers_bench
  import cwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_sys_in, arst_n_in;      // Clock and reset
  logic [7:0]  reg_addr;                   // Register port
  logic [31:0] reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd;
  logic        rtc_req;                    // Tick request to model
  logic [19:0] rtc_time;                   // Time handed to model
  logic        sec_tick;                   // Model to block
  logic [4:0]  rtc_hour;
  logic [5:0]  rtc_min, rtc_sec;
  logic [2:0]  rtc_day;
  logic        power_fail, nv_save, nv_restore;
  logic [3:0]  nv_state_sv, nv_state_ld;   // Saved and restored states
  logic [3:0]  timer_out, exp_out;         // Seen and expected outputs
  int          failures, checks_done;
  // Qualifying days per mode code, bit 0 = Monday
  logic [6:0]  day_mask [12] = '{7'h00, 7'h7f, 7'h01, 7'h02, 7'h04, 7'h08,
                                 7'h10, 7'h20, 7'h40, 7'h1f, 7'h3f, 7'h60};

  cwt_rtc_model u_rtc (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .req_in(rtc_req),
    .time_in(rtc_time), .tick_out(sec_tick), .hour_out(rtc_hour), .min_out(rtc_min),
    .sec_out(rtc_sec), .day_out(rtc_day));

  cwt_timers #(.N(4)) u_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .rtc_sec_tick_in(sec_tick),
    .rtc_hour_in(rtc_hour), .rtc_min_in(rtc_min), .rtc_sec_in(rtc_sec),
    .rtc_weekday_in(rtc_day), .power_fail_in(power_fail), .nv_save_out(nv_save),
    .nv_state_out(nv_state_sv), .nv_restore_in(nv_restore), .nv_state_in(nv_state_ld),
    .calendar_timer_state_out(timer_out));

  // ****************************************************************
  // Clock and watchdog
  // ****************************************************************
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard, counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    summarize();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_bits

  function automatic logic [7:0] ad(input logic [1:0] t, input logic [1:0] w);
    return {2'h0, t, w, 2'h0};
  endfunction : ad

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys_in);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_in);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // One tick; waits past the four-timer scan, keeping ticks well apart
  task automatic tick(input logic [5:0] s, input logic [2:0] d);
    @(posedge clk_sys_in);
    rtc_req  <= 1'b1;
    rtc_time <= {5'd23, 6'd59, s, d};
    @(posedge clk_sys_in);
    rtc_req  <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask : tick

  // Power-fail save or startup restore pulse
  task automatic nv_pulse(input logic save, input logic [3:0] st);
    @(posedge clk_sys_in);
    power_fail  <= save;
    nv_restore  <= !save;
    nv_state_ld <= st;
    @(posedge clk_sys_in);
    power_fail  <= 1'b0;
    nv_restore  <= 1'b0;
    #1;
  endtask : nv_pulse

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] v;
    logic [1:0]  t;
    {arst_n_in, reg_wr, reg_rd, rtc_req, power_fail, nv_restore} = 6'h00;
    {reg_addr, reg_wdata, rtc_time, nv_state_ld} = '0;
    failures = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    #1;
    chk_bits("reset outputs", 4'h0, timer_out);
    rd(ad(2'h2, `CWT_OFS_STATUS), v);
    chk_reg("reset status", 32'h0, v);
    // Distinct seconds per timer so a tick touches one timer only
    for (int i = 0; i < 4; i++) begin
      wr(ad(2'(i), `CWT_OFS_ON), {15'h0, 5'd23, 6'd59, 6'(2 * i)});
      wr(ad(2'(i), `CWT_OFS_OFF), {15'h0, 5'd23, 6'd59, 6'(2 * i + 1)});
    end
    rd(ad(2'h3, `CWT_OFS_OFF), v);
    chk_reg("off time", {15'h0, 5'd23, 6'd59, 6'd7}, v);
    exp_out = 4'h0;
    // Every mode on every weekday, modes spread over the four timers
    for (int m = 0; m < 12; m++) begin
      t = 2'(m % 4);
      wr(ad(t, `CWT_OFS_MODE), 32'(m));
      if (m == 0) begin
        wr(ad(t, `CWT_OFS_STATUS), 32'h1);
      end
      for (int d = 0; d < 7; d++) begin
        tick(6'(2 * t), 3'(d));
        exp_out[t] = day_mask[m][d];
        chk_bits("on time", exp_out, timer_out);
        rd(ad(t, `CWT_OFS_STATUS), v);
        chk_reg("status", {30'h0, m != 0, exp_out[t]}, v);
        tick(6'(2 * t + 1), 3'(d));
        exp_out[t] = 1'b0;
        chk_bits("off time", exp_out, timer_out);
      end
    end
    // Timer 1 is weekdays only: forced state lasts until its own reversal
    wr(ad(2'h1, `CWT_OFS_STATUS), 32'h1);
    chk_bits("force on", 4'h2, timer_out);
    tick(6'd3, 3'd5);
    chk_bits("force held", 4'h2, timer_out);
    tick(6'd3, 3'd0);
    chk_bits("force ended", 4'h0, timer_out);
    wr(ad(2'h1, `CWT_OFS_STATUS), 32'h1);
    nv_pulse(1'b1, 4'h0);
    chk_bits("nv save", 4'h1, {3'h0, nv_save});
    chk_bits("nv state", 4'h2, nv_state_sv);
    wr(ad(2'h1, `CWT_OFS_STATUS), 32'h0);
    chk_bits("force off", 4'h0, timer_out);
    // Restore reaches only timers in use
    wr(ad(2'h3, `CWT_OFS_MODE), 32'h0);
    nv_pulse(1'b0, 4'hf);
    chk_bits("restore", 4'h7, timer_out);
    wr(ad(2'h0, `CWT_OFS_MODE), 32'h0);
    chk_bits("disable", 4'h6, timer_out);
    rd(ad(2'h2, `CWT_OFS_STATUS), v);
    chk_reg("status active", 32'h3, v);
    // Illegal code is kept but acts as disabled
    wr(ad(2'h1, `CWT_OFS_MODE), 32'hc);
    chk_bits("illegal mode", 4'h4, timer_out);
    rd(ad(2'h1, `CWT_OFS_MODE), v);
    chk_reg("mode readback", 32'hc, v);
    rd(ad(2'h1, `CWT_OFS_STATUS), v);
    chk_reg("status unused", 32'h0, v);
    rd(8'h40, v);
    chk_reg("unmapped", 32'h0, v);
    summarize();
  end
endmodule : calendar_weekday_timers_bench
